// ===== rtl/ldm_mux.sv
// Eight-digit multiplexed seven-segment drive with blanking.
// Assumes latched BCD data, point position and overflow are synchronous.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Scan eight digits, 244 us each, 500 Hz.
// - Insert 6 us blank gap between digits.
// - Blank leading zeros until nonzero or point.
// - Never blank digits right of decimal point.
// - Overflow disables zero suppression entirely.
// - Quarter timebase slows scan to 125 Hz.
// - Scan timing derives from the oscillator timebase.
// - Overflow lights point in top digit slot.
// - Test lights everything unless display off.
module ldm_mux #(
  parameter int unsigned DIGIT_CYC = ldm_pkg::DIGIT_CYC,
  parameter int unsigned GAP_CYC   = ldm_pkg::GAP_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [31:0] digit_data,
  input  wire logic [2:0]  point_pos,
  input  wire logic        point_en,
  input  wire logic        overflow,
  input  wire logic        slow_timebase,
  input  wire logic        display_test,
  input  wire logic        display_off,
  output logic      [6:0]  seg_out,
  output logic             dp_out,
  output logic      [7:0]  digit_sel
);
  localparam int unsigned SLOW_DIGIT = DIGIT_CYC * ldm_pkg::SLOW_FACTOR;
  localparam int unsigned SLOW_GAP   = GAP_CYC * ldm_pkg::SLOW_FACTOR;
  localparam int unsigned CW         = $clog2(SLOW_DIGIT + 1);

  ldm_pkg::ldm_state_e state_r;
  logic [CW-1:0] cnt_r;
  logic [2:0]    idx_r;

  // Digit i is significant-blank when it and all above it are zero
  // and none of them lies at or right of the point.
  logic [7:0] zero_d;
  logic [7:0] keep_d;
  logic [7:0] blank_chain;
  genvar gi;
  generate
    for (gi = 0; gi < ldm_pkg::DIGITS; gi++) begin : g_lz
      assign zero_d[gi] = (digit_data[gi*4 +: 4] == 4'h0);
      assign keep_d[gi] = point_en && (3'(gi) <= point_pos);
      if (gi == ldm_pkg::DIGITS - 1) begin : g_top
        assign blank_chain[gi] = zero_d[gi] && !keep_d[gi];
      end else begin : g_low
        assign blank_chain[gi] = blank_chain[gi+1] && zero_d[gi]
                                 && !keep_d[gi];
      end
    end
  endgenerate

  wire [3:0] cur_digit   = digit_data[idx_r*4 +: 4];
  wire       cur_blank   = blank_chain[idx_r] && !overflow;
  wire       cur_point   = point_en && (idx_r == point_pos);
  wire       cur_ovf_dp  = overflow && (idx_r == ldm_pkg::MSD_INDEX);
  wire [6:0] dec_seg;
  ldm_seg_decode ldm_seg_decode_i (
    .digit (cur_digit),
    .seg   (dec_seg)
  );

  // Slot lengths follow the supplied timebase; a quarter-rate timebase
  // is modelled by stretching every slot fourfold.
  // The show state keeps the digit lit for a full slot and spends one
  // more edge turning it off, so the gap state is one edge short of the
  // dark time; GAP_CYC must therefore be at least 2.
  wire [CW-1:0] show_len = slow_timebase ? CW'(SLOW_DIGIT)
                                         : CW'(DIGIT_CYC);
  wire [CW-1:0] gap_len  = slow_timebase ? CW'(SLOW_GAP - 2)
                                         : CW'(GAP_CYC - 2);
  wire show_done = (state_r == ldm_pkg::LDM_SHOW) && (cnt_r >= show_len);
  wire gap_done  = (state_r == ldm_pkg::LDM_GAP) && (cnt_r >= gap_len);

  wire       lit_ok     = !display_off;
  wire [6:0] seg_nxt    = !lit_ok ? ldm_pkg::SEG_OFF :
                          display_test ? ldm_pkg::SEG_ALL_ON :
                          cur_blank ? ldm_pkg::SEG_OFF : dec_seg;
  wire       dp_nxt     = lit_ok && (display_test || cur_ovf_dp ||
                          (cur_point && !cur_blank));
  wire [7:0] onehot_sel = 8'h01 << idx_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r   <= ldm_pkg::LDM_GAP;
      cnt_r     <= '0;
      idx_r     <= ldm_pkg::INDEX_RESET;
      seg_out   <= ldm_pkg::SEG_OFF;
      dp_out    <= 1'b0;
      digit_sel <= ldm_pkg::DIG_OFF;
    end else begin
      unique case (state_r)
        ldm_pkg::LDM_GAP: begin
          // Segments settle for the coming digit while drivers are off.
          seg_out   <= gap_done ? seg_nxt : ldm_pkg::SEG_OFF;
          dp_out    <= gap_done ? dp_nxt : 1'b0;
          digit_sel <= ldm_pkg::DIG_OFF;
          cnt_r     <= gap_done ? '0 : cnt_r + CW'(1);
          if (gap_done) begin
            state_r <= ldm_pkg::LDM_SHOW;
          end
        end
        ldm_pkg::LDM_SHOW: begin
          seg_out   <= show_done ? ldm_pkg::SEG_OFF : seg_nxt;
          dp_out    <= show_done ? 1'b0 : dp_nxt;
          digit_sel <= (show_done || !lit_ok) ? ldm_pkg::DIG_OFF
                                              : onehot_sel;
          cnt_r     <= show_done ? '0 : cnt_r + CW'(1);
          if (show_done) begin
            state_r <= ldm_pkg::LDM_GAP;
            idx_r   <= idx_r + 3'h1;
          end
        end
      endcase
    end
  end

  // Helper: cycles spent with no digit selected since the last show.
  logic [CW-1:0] off_cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      off_cnt_r <= '0;
    end else begin
      // Saturates so a long display-off spell cannot wrap back to a
      // short count.
      off_cnt_r <= (digit_sel != ldm_pkg::DIG_OFF) ? '0 :
                   (&off_cnt_r) ? off_cnt_r : off_cnt_r + CW'(1);
    end
  end

  // A digit that comes back as display off ends has no gap to keep.
  gap_min_a: assert property (
    @(posedge clk) disable iff (rst)
    ($rose(|digit_sel) && !$past(display_off, 2)) |->
      $past(off_cnt_r) >= CW'(GAP_CYC - 1))
    else $error("Digit enabled before blanking gap elapsed.");

  one_digit_a: assert property (
    @(posedge clk) disable iff (rst)
    $onehot0(digit_sel))
    else $error("More than one digit selected.");

  gap_dark_a: assert property (
    @(posedge clk) disable iff (rst)
    $fell(|digit_sel) |-> (seg_out == ldm_pkg::SEG_OFF) && !dp_out)
    else $error("Segments driven while digits deselected.");

  test_all_a: assert property (
    @(posedge clk) disable iff (rst)
    (state_r == ldm_pkg::LDM_SHOW && !show_done && display_test
     && !display_off) |=> (seg_out == ldm_pkg::SEG_ALL_ON) && dp_out)
    else $error("Display test did not light all segments.");

  off_blank_a: assert property (
    @(posedge clk) disable iff (rst)
    display_off |=> (digit_sel == ldm_pkg::DIG_OFF))
    else $error("Digit driven while display off.");

  ovf_point_a: assert property (
    @(posedge clk) disable iff (rst)
    (state_r == ldm_pkg::LDM_SHOW && !show_done && overflow
     && !display_off && idx_r == ldm_pkg::MSD_INDEX) |=> dp_out)
    else $error("Overflow point missing on top digit.");

  ovf_show_a: assert property (
    @(posedge clk) disable iff (rst)
    (state_r == ldm_pkg::LDM_SHOW && !show_done && overflow
     && !display_off && !display_test) |=> seg_out != ldm_pkg::SEG_OFF)
    else $error("Digit blanked during overflow.");

  right_show_a: assert property (
    @(posedge clk) disable iff (rst)
    (state_r == ldm_pkg::LDM_SHOW && !show_done && point_en
     && idx_r <= point_pos && !display_off) |=> seg_out != ldm_pkg::SEG_OFF)
    else $error("Digit right of point was blanked.");

  lead_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    (state_r == ldm_pkg::LDM_SHOW && !show_done && digit_data == 32'h0
     && !point_en && !overflow && !display_test && idx_r == 3'h7)
      |=> seg_out == ldm_pkg::SEG_OFF)
    else $error("Leading zero not blanked.");

  slot_len_a: assert property (
    @(posedge clk) disable iff (rst)
    ($rose(state_r == ldm_pkg::LDM_SHOW) && !slow_timebase)
      |-> (state_r == ldm_pkg::LDM_SHOW) [*8])
    else $error("Digit slot ended too early.");

  // Helper: cycles in a row with a digit selected.
  logic [CW-1:0] on_cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      on_cnt_r <= '0;
    end else begin
      on_cnt_r <= (digit_sel != ldm_pkg::DIG_OFF) ? on_cnt_r + CW'(1) : '0;
    end
  end

  lit_max_a: assert property (
    @(posedge clk) disable iff (rst)
    (|digit_sel) |-> on_cnt_r < CW'(SLOW_DIGIT))
    else $error("Digit held longer than the slowest slot.");

  sel_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    (|digit_sel && |$past(digit_sel)) |-> digit_sel == $past(digit_sel))
    else $error("Digit changed with no blanking gap.");

  point_show_a: assert property (
    @(posedge clk) disable iff (rst)
    (state_r == ldm_pkg::LDM_SHOW && !show_done && point_en
     && idx_r == point_pos && !display_off) |=> dp_out)
    else $error("Decimal point missing on its digit.");

  off_seg_a: assert property (
    @(posedge clk) disable iff (rst)
    display_off |=> (seg_out == ldm_pkg::SEG_OFF) && !dp_out)
    else $error("Segment driven while display off.");

  scan_wrap_c: cover property (
    @(posedge clk) disable iff (rst)
    show_done && idx_r == ldm_pkg::MSD_INDEX);
  ovf_c: cover property (
    @(posedge clk) disable iff (rst) overflow && dp_out);
  test_c: cover property (
    @(posedge clk) disable iff (rst) display_test && |digit_sel);
  slow_c: cover property (
    @(posedge clk) disable iff (rst) slow_timebase && show_done);
endmodule
`default_nettype wire

// ===== rtl/ldm_pkg.sv
// Constants shared by the eight-digit LED multiplexer.
// Assumes a 200 MHz system clock.
package ldm_pkg;
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned DIGITS          = 8;
  localparam int unsigned DIGIT_TIME_NS   = 244000;
  localparam int unsigned GAP_TIME_NS     = 6000;
  localparam int unsigned CLK_PERIOD_NS   = 1000 / CLK_MHZ;
  // Standard timebase: lit time of a digit, rounded down.
  localparam int unsigned DIGIT_CYC       = DIGIT_TIME_NS / CLK_PERIOD_NS;
  // Blanking gap between digits, a least time, rounded up.
  localparam int unsigned GAP_CYC         =
    (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Slow timebase stretches every slot by this factor.
  localparam int unsigned SLOW_FACTOR     = 4;
  localparam int unsigned MEAS_SPACE_MS   = 200;
  localparam int unsigned MEAS_SLOW_MS    = 800;
  localparam logic [6:0]  SEG_ALL_ON      = 7'h7F;
  localparam logic [6:0]  SEG_OFF         = 7'h00;
  localparam logic [7:0]  DIG_OFF         = 8'h00;
  localparam logic [2:0]  MSD_INDEX       = 3'h7;
  localparam logic [2:0]  INDEX_RESET     = 3'h0;
  typedef enum logic [1:0] {
    LDM_GAP  = 2'b01,
    LDM_SHOW = 2'b10
  } ldm_state_e;
endpackage

// ===== rtl/ldm_seg_decode.sv
// Hex digit to seven-segment pattern, bit 0 is segment a.
// Pure combinational leaf used by the multiplexer.
`timescale 1ns/100ps
`default_nettype none
module ldm_seg_decode (
  input  wire logic [3:0] digit,
  output logic      [6:0] seg
);
  always_comb begin
    unique case (digit)
      4'h0: seg = 7'h3F;
      4'h1: seg = 7'h06;
      4'h2: seg = 7'h5B;
      4'h3: seg = 7'h4F;
      4'h4: seg = 7'h66;
      4'h5: seg = 7'h6D;
      4'h6: seg = 7'h7D;
      4'h7: seg = 7'h07;
      4'h8: seg = 7'h7F;
      4'h9: seg = 7'h6F;
      4'hA: seg = 7'h77;
      4'hB: seg = 7'h7C;
      4'hC: seg = 7'h39;
      4'hD: seg = 7'h5E;
      4'hE: seg = 7'h79;
      4'hF: seg = 7'h71;
    endcase
  end
endmodule
`default_nettype wire

// ===== verification/ldm_display.sv
// Common cathode display model: remembers what each digit last showed.
// Assumes one-hot active-high digit enables and active-high segments.
`timescale 1ns/100ps
`default_nettype none
module ldm_display (
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic [6:0] seg_out,
  input  wire logic       dp_out,
  input  wire logic [7:0] digit_sel,
  output logic      [7:0] seen [8]
);
  // A digit that is never enabled keeps the dark value left by clr.
  always_ff @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (clr) begin
        seen[i] <= 8'h00;
      end else if (digit_sel[i]) begin
        seen[i] <= {dp_out, seg_out};
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/led_digit_multiplexer_test.sv
// Self-checking bench for the eight-digit LED multiplexer.
// Assumes short slots (20 lit, 3 dark cycles) set through parameters.
`timescale 1ns/100ps
`default_nettype none
module led_digit_multiplexer_test;
  localparam int SLOT = 20;
  localparam int GAP  = 3;
  logic clk = 1'b0, rst = 1'b1, clr = 1'b0;
  logic [31:0] digit_data = 32'h0;
  logic [2:0] point_pos = 3'h0;
  logic point_en = 1'b0, overflow = 1'b0, slow_timebase = 1'b0;
  logic display_test = 1'b0, display_off = 1'b0, dp_out;
  logic [6:0] seg_out;
  logic [7:0] digit_sel;
  logic [7:0] seen [8];
  int err_count = 0, total_checks = 0;
  ldm_mux #(.DIGIT_CYC(SLOT), .GAP_CYC(GAP)) ldm_mux_i (.clk(clk),
    .rst(rst), .digit_data(digit_data), .point_pos(point_pos),
    .point_en(point_en), .overflow(overflow), .slow_timebase(slow_timebase),
    .display_test(display_test), .display_off(display_off),
    .seg_out(seg_out), .dp_out(dp_out), .digit_sel(digit_sel));
  ldm_display ldm_display_i (.clk(clk), .clr(clr), .seg_out(seg_out),
    .dp_out(dp_out), .digit_sel(digit_sel), .seen(seen));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Measures every lit slot, the dark gap after it and, inside that gap,
  // the cycles before the next digit's segments are set up. Expects
  // display test on, so every digit's segments are lit.
  task automatic scan_chk(input int slot, input int gap);
    int n, g, d;
    for (n = 0; n < 4000 && digit_sel === 8'h01; n++) @(negedge clk);
    for (n = 0; n < 4000 && digit_sel !== 8'h01; n++) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      n = 0;
      g = 0;
      d = 0;
      while (digit_sel === (8'h01 << i) && n < 1000) begin
        n++;
        @(negedge clk);
      end
      while (digit_sel === 8'h00 && g < 400) begin
        if (seg_out === 7'h00 && dp_out === 1'b0) begin
          d++;
        end
        g++;
        @(negedge clk);
      end
      chk(n, slot, "slot length");
      chk(g, gap, "dark gap length");
      chk(d, gap - 1, "segments ahead of digit");
    end
  endtask
  // Applies one display setting and compares each digit after two scans.
  task automatic show_chk(input logic [31:0] d, input logic [3:0] pp,
                          input logic [2:0] fl, input logic [63:0] exp);
    @(posedge clk);
    digit_data <= d;
    {point_en, point_pos} <= pp;
    {overflow, display_test, display_off} <= fl;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (400) @(negedge clk);
    for (int i = 0; i < 8; i++) chk(seen[i], exp[8*i +: 8], "digit pattern");
  endtask
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    show_chk(32'h0000_1230, 4'h0, 3'h0, 64'h0000_0000_065B_4F3F);
    show_chk(32'h1000_0000, 4'h0, 3'h0, 64'h063F_3F3F_3F3F_3F3F);
    show_chk(32'h0, 4'h0, 3'h0, 64'h0);
    show_chk(32'h0, 4'hA, 3'h0, 64'h0000_0000_00BF_3F3F);
    show_chk(32'h0, 4'h0, 3'h4, 64'hBF3F_3F3F_3F3F_3F3F);
    show_chk(32'h0, 4'h0, 3'h2, 64'hFFFF_FFFF_FFFF_FFFF);
    show_chk(32'h0, 4'h0, 3'h3, 64'h0);
    show_chk(32'h0, 4'h0, 3'h2, 64'hFFFF_FFFF_FFFF_FFFF);
    scan_chk(SLOT, GAP);
    @(posedge clk);
    slow_timebase <= 1'b1;
    scan_chk(SLOT * 4, GAP * 4);
    scan_chk(SLOT * 4, GAP * 4);
    end_of_test();
  end
endmodule
`default_nettype wire
